// ===== src/tape_ctrl_status_register.sv
`include "tape_status_map.svh"
// What this block does
// - Read-only status word at offset two
// - Special condition on error or exception; init clears
// - Refused write or bus error also sets special
// - Bits 14, 9, 8 read zero
// - Sanity error: no message, class seven
// - Pointer write while not ready is refused
// - DMA bus error sets memory flag
// - Need-buffer set by init, cleared by setup
// - Need-buffer rejects other commands, class three
// - Ready when idle; low pointer write clears
// - Init clears ready; diagnostics pass sets it
// - Offline flag updated only at completion
// - Offline gives attention or nonexecutable reject; here reject only, at a class-zero non-setup completion
// - Fatal class valid only with class seven
// - Fatal zero: diagnostic failure, refuse until init
// - Class codes: normal, attention, alert, reject
// - Class codes four to seven: error kinds
// - Extended word written at completion and attention
// - Extended word bit layout fixed order
// - High pointer bit 15 forces initialize
`default_nettype none
module tape_ctrl_status_register #(
    parameter int DATA_W = 16
) (
    clk_sys,
    reset_n,
    bus_addr,
    bus_wdata,
    bus_write,
    bus_read,
    bus_rdata,
    diag_done,
    diag_pass,
    sanity_fault,
    dma_bus_error,
    cmd_done,
    cmd_is_setup,
    cmd_buf_addr_ok,
    cmd_term_class,
    cmd_exception,
    attention_event,
    tape_mark_seen,
    record_short,
    logical_end,
    record_long,
    write_lock_error,
    illegal_command,
    illegal_address,
    tape_moving,
    transport_online,
    interrupt_enable,
    volume_check,
    write_locked,
    beginning_of_tape,
    end_of_tape_marker,
    cmd_start,
    cmd_pointer,
    init_pulse,
    msg_write,
    msg_word_index,
    extended_tape_status_word0
);
    input wire logic clk_sys; // System clock
    input wire logic reset_n; // Synchronous reset, active low
    input wire logic [3:0] bus_addr; // Byte offset from base
    input wire logic [DATA_W-1:0] bus_wdata; // Host write data
    input wire logic bus_write; // Write strobe, one cycle
    input wire logic bus_read; // Read strobe
    output logic [DATA_W-1:0] bus_rdata; // Registered read data
    input wire logic diag_done; // Diagnostics finished pulse
    input wire logic diag_pass; // Diagnostics result
    input wire logic sanity_fault; // Internal error pulse
    input wire logic dma_bus_error; // DMA ended in bus error
    input wire logic cmd_done; // Command completion pulse
    input wire logic cmd_is_setup; // Completed command was buffer setup
    input wire logic cmd_buf_addr_ok; // Setup supplied a valid address
    input wire logic [2:0] cmd_term_class; // Class from executor
    input wire logic cmd_exception; // Exception without class
    input wire logic attention_event; // Attention report pulse
    input wire logic tape_mark_seen; // Live extended status inputs
    input wire logic record_short;
    input wire logic logical_end;
    input wire logic record_long;
    input wire logic write_lock_error;
    input wire logic illegal_command;
    input wire logic illegal_address;
    input wire logic tape_moving;
    input wire logic transport_online;
    input wire logic interrupt_enable;
    input wire logic volume_check;
    input wire logic write_locked;
    input wire logic beginning_of_tape;
    input wire logic end_of_tape_marker;
    output logic cmd_start; // Accepted command pointer pulse
    output logic [23:0] cmd_pointer; // Full 24-bit command pointer
    output logic init_pulse; // Initialize pulse to controller
    output logic msg_write; // Message word store pulse
    output logic [1:0] msg_word_index; // Word index in message buffer
    output logic [DATA_W-1:0] extended_tape_status_word0; // Stored word

    // ----------------------------------------
    // Internal state
    // ----------------------------------------
    tape_status_pkg::ctrl_state_e state; // Sequencer state
    logic special_condition; // Sticky summary flag
    logic sanity_check_error; // Internal error flag
    logic register_write_refused; // Refused pointer write
    logic bus_error_nonexistent_memory; // DMA bus error flag
    logic need_msg_buffer_addr; // No message buffer yet
    logic transport_offline; // Snapshot at completion
    logic [1:0] fatal_class; // Fatal code
    logic [2:0] termination_class; // Last class
    logic [7:0] ptr_high; // High pointer bits
    logic [DATA_W-1:0] next_xst; // Extended word being built
    logic [2:0] next_class; // Effective class of a completion
    logic wr_low; // Low pointer write decode
    logic wr_high; // High pointer write decode
    logic init_req; // Initialize request decode
    logic refuse; // Pointer write while not ready
    logic subsystem_ready; // Ready decode from state

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign wr_low = bus_write && (bus_addr == `OFS_CMD_PTR_LOW);
    assign wr_high = bus_write && (bus_addr == `OFS_CMD_PTR_HIGH);
    assign init_req = wr_high && bus_wdata[`BIT_INIT_REQ];
    assign subsystem_ready = (state == tape_status_pkg::ST_IDLE);
    assign refuse = (wr_low || (wr_high && !init_req)) && !subsystem_ready;

    // ----------------------------------------
    // Effective termination class
    // ----------------------------------------
    // Reject overrides executor result while buffer is missing
    always_comb begin
        next_class = cmd_term_class;
        if (need_msg_buffer_addr && !cmd_is_setup) begin
            next_class = tape_status_pkg::CL_FUNC_REJECT;
        end else if (!cmd_is_setup && !transport_online && cmd_term_class == `CL_ZERO) begin
            next_class = tape_status_pkg::CL_FUNC_REJECT;
        end
    end

    // ----------------------------------------
    // Extended status word assembly
    // ----------------------------------------
    // Extended word layout
    always_comb begin
        next_xst = `WORD_ZERO;
        next_xst[`XB_TAPE_MARK] = tape_mark_seen;
        next_xst[`XB_SHORT] = record_short;
        next_xst[`XB_LOGICAL_END] = logical_end;
        next_xst[`XB_LONG] = record_long;
        next_xst[`XB_WLOCK_ERR] = write_lock_error;
        // Offline at a non-setup completion counts as nonexecutable; missing buffer does not
        next_xst[`XB_NONEXEC] = !transport_online && cmd_done && !cmd_is_setup;
        next_xst[`XB_ILL_CMD] = illegal_command;
        next_xst[`XB_ILL_ADDR] = illegal_address;
        next_xst[`XB_MOVING] = tape_moving;
        next_xst[`XB_ONLINE] = transport_online;
        next_xst[`XB_INT_EN] = interrupt_enable;
        next_xst[`XB_VOL_CHECK] = volume_check;
        next_xst[`XB_WLOCKED] = write_locked;
        next_xst[`XB_BEG] = beginning_of_tape;
        next_xst[`XB_END] = end_of_tape_marker;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Diagnostics after init, then idle/busy; fatal parks in dead
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            state <= tape_status_pkg::ST_DIAG;
        end else begin
            case (state)
                tape_status_pkg::ST_DIAG: begin
                    if (diag_done) begin
                        state <= diag_pass ? tape_status_pkg::ST_IDLE : tape_status_pkg::ST_DEAD;
                    end
                end
                tape_status_pkg::ST_IDLE: begin
                    if (sanity_fault) begin
                        state <= tape_status_pkg::ST_DEAD;
                    end else if (wr_low) begin
                        state <= tape_status_pkg::ST_BUSY;
                    end
                end
                tape_status_pkg::ST_BUSY: begin
                    if (sanity_fault) begin
                        state <= tape_status_pkg::ST_DEAD;
                    end else if (cmd_done) begin
                        state <= tape_status_pkg::ST_IDLE;
                    end
                end
                tape_status_pkg::ST_DEAD: state <= tape_status_pkg::ST_DEAD;
                default: state <= tape_status_pkg::ST_DIAG;
            endcase
        end
    end

    // ----------------------------------------
    // Command pointer and start
    // ----------------------------------------
    // Refused writes never reach the pointer
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            ptr_high <= `PTR_HI_RESET;
            cmd_pointer <= {`PTR_HI_RESET, `WORD_ZERO};
            cmd_start <= 1'b0;
            init_pulse <= !reset_n ? 1'b0 : 1'b1;
        end else begin
            init_pulse <= 1'b0;
            cmd_start <= 1'b0;
            if (wr_high && subsystem_ready) begin
                ptr_high <= bus_wdata[`FLD_PTR_HI_HI:`FLD_PTR_HI_LO];
            end
            if (wr_low && subsystem_ready) begin
                cmd_pointer <= {ptr_high, bus_wdata[15:0]};
                cmd_start <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    // Sticky until initialize; init wins over an event in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            register_write_refused <= 1'b0;
            bus_error_nonexistent_memory <= 1'b0;
            sanity_check_error <= 1'b0;
        end else begin
            if (refuse) begin
                register_write_refused <= 1'b1;
            end
            if (dma_bus_error) begin
                bus_error_nonexistent_memory <= 1'b1;
            end
            if (sanity_fault || (state == tape_status_pkg::ST_DIAG && diag_done && !diag_pass)) begin
                sanity_check_error <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Special condition, classes and offline
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            special_condition <= 1'b0;
            termination_class <= `CL_ZERO;
            fatal_class <= `FT_ZERO;
            transport_offline <= 1'b0;
        end else if (sanity_fault || (state == tape_status_pkg::ST_DIAG && diag_done && !diag_pass)) begin
            special_condition <= 1'b1;
            termination_class <= tape_status_pkg::CL_FATAL;
            fatal_class <= `FT_DIAG_FAIL;
        end else begin
            if (refuse || dma_bus_error) begin
                special_condition <= 1'b1;
            end
            if (state == tape_status_pkg::ST_BUSY && cmd_done) begin
                termination_class <= next_class;
                fatal_class <= `FT_ZERO;
                transport_offline <= !transport_online;
                if (next_class != `CL_ZERO || cmd_exception || dma_bus_error) begin
                    special_condition <= 1'b1;
                end
            end else if (attention_event && state != tape_status_pkg::ST_DEAD) begin
                termination_class <= tape_status_pkg::CL_ATTENTION;
                special_condition <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Need buffer flag
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            need_msg_buffer_addr <= 1'b1;
        end else if (state == tape_status_pkg::ST_BUSY && cmd_done && cmd_is_setup && cmd_buf_addr_ok) begin
            need_msg_buffer_addr <= 1'b0;
        end
    end

    // ----------------------------------------
    // Message buffer store
    // ----------------------------------------
    // Word four (index 3) of the message buffer; suppressed on sanity error
    always_ff @(posedge clk_sys) begin
        if (!reset_n || init_req) begin
            msg_write <= 1'b0;
            msg_word_index <= 2'h0;
            extended_tape_status_word0 <= `WORD_ZERO;
        end else begin
            msg_write <= 1'b0;
            if (((state == tape_status_pkg::ST_BUSY && cmd_done) || attention_event)
                && !sanity_fault && !sanity_check_error && !need_msg_buffer_addr) begin
                msg_write <= 1'b1;
                msg_word_index <= 2'h3;
                extended_tape_status_word0 <= next_xst;
            end
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    // Read-only status word
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_rdata <= `WORD_ZERO;
        end else if (bus_read && bus_addr == `OFS_MAJOR_STATUS) begin
            bus_rdata <= `WORD_ZERO;
            bus_rdata[`BIT_SPECIAL] <= special_condition;
            bus_rdata[`BIT_SANITY] <= sanity_check_error;
            bus_rdata[`BIT_REFUSED] <= register_write_refused;
            bus_rdata[`BIT_BUS_ERR] <= bus_error_nonexistent_memory;
            bus_rdata[`BIT_NEED_BUF] <= need_msg_buffer_addr;
            bus_rdata[`BIT_READY] <= subsystem_ready;
            bus_rdata[`BIT_OFFLINE] <= transport_offline;
            bus_rdata[`FLD_FATAL_HI:`FLD_FATAL_LO] <=
                (special_condition && termination_class == tape_status_pkg::CL_FATAL) ? fatal_class : `FT_ZERO;
            bus_rdata[`FLD_TERM_HI:`FLD_TERM_LO] <= termination_class;
        end else begin
            // Unmapped or idle reads return zero
            bus_rdata <= `WORD_ZERO;
        end
    end
endmodule : tape_ctrl_status_register
`default_nettype wire

// ===== src/tape_status_map.svh
`ifndef TAPE_STATUS_MAP_SVH
`define TAPE_STATUS_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses from the board base)
// ----------------------------------------
`define OFS_CMD_PTR_LOW 4'h0
`define OFS_CMD_PTR_HIGH 4'h2
`define OFS_MAJOR_STATUS 4'h2
// ----------------------------------------
// Major status word bit positions
// ----------------------------------------
`define BIT_SPECIAL 15
`define BIT_SANITY 13
`define BIT_REFUSED 12
`define BIT_BUS_ERR 11
`define BIT_NEED_BUF 10
`define BIT_READY 7
`define BIT_OFFLINE 6
`define FLD_FATAL_HI 5
`define FLD_FATAL_LO 4
`define FLD_TERM_HI 3
`define FLD_TERM_LO 1
// ----------------------------------------
// High pointer write: initialize bit and address field
// ----------------------------------------
`define BIT_INIT_REQ 15
`define FLD_PTR_HI_HI 7
`define FLD_PTR_HI_LO 0
// ----------------------------------------
// Extended status word bit positions
// ----------------------------------------
`define XB_TAPE_MARK 15
`define XB_SHORT 14
`define XB_LOGICAL_END 13
`define XB_LONG 12
`define XB_WLOCK_ERR 11
`define XB_NONEXEC 10
`define XB_ILL_CMD 9
`define XB_ILL_ADDR 8
`define XB_MOVING 7
`define XB_ONLINE 6
`define XB_INT_EN 5
`define XB_VOL_CHECK 4
`define XB_WLOCKED 2
`define XB_BEG 1
`define XB_END 0
// ----------------------------------------
// Reset values and constant codes
// ----------------------------------------
`define CL_ZERO 3'h0
`define FT_ZERO 2'h0
`define FT_DIAG_FAIL 2'h0
`define PTR_HI_RESET 8'h00
`define WORD_ZERO 16'h0000
`endif

// ===== src/tape_status_pkg.sv
`default_nettype none
package tape_status_pkg;
    // Termination class codes
    typedef enum logic [2:0] {
        CL_NORMAL = 3'b000,
        CL_ATTENTION = 3'b001,
        CL_STATUS_ALERT = 3'b010,
        CL_FUNC_REJECT = 3'b011,
        CL_RECOV_DOWN = 3'b100,
        CL_RECOV_STILL = 3'b101,
        CL_UNRECOV = 3'b110,
        CL_FATAL = 3'b111
    } term_class_e;

    // Controller sequencing states
    typedef enum logic [1:0] {
        ST_DIAG = 2'b00,
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10,
        ST_DEAD = 2'b11
    } ctrl_state_e;
endpackage : tape_status_pkg
`default_nettype wire

// ===== verification/tape_status_sva.sv
`default_nettype none
module tape_status_sva #(
    parameter int DATA_W = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_write,
    input wire logic cmd_done,
    input wire logic attention_event,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic cmd_start,
    input wire logic init_pulse,
    input wire logic msg_write,
    input wire logic [1:0] msg_word_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Clocking and request shapes
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // High pointer write asking for initialize
    sequence s_init_wr;
        bus_write && bus_addr == 4'h2 && bus_wdata[15];
    endsequence
    // Low pointer write that may start a command
    sequence s_low_wr;
        bus_write && bus_addr == 4'h0;
    endsequence
    // ----------------------------------------
    // Status word relations
    // ----------------------------------------
    // Read data is zero when idle, so these hold at all times
    AST_UNUSED_BITS_ZERO: assert property (bus_rdata[14] == 1'h0 && bus_rdata[9:8] == 2'h0)
        else $error("unused status bits not zero");
    AST_FATAL_ONLY_CLASS7: assert property (bus_rdata[5:4] != 2'h0 |-> bus_rdata[15] && bus_rdata[3:1] == 3'h7)
        else $error("fatal field set outside class seven");
    AST_REFUSED_SETS_SPECIAL: assert property (bus_rdata[12] |-> bus_rdata[15])
        else $error("refused write without special flag");
    AST_BUSERR_SETS_SPECIAL: assert property (bus_rdata[11] |-> bus_rdata[15])
        else $error("bus error without special flag");
    AST_SANITY_CLASS7: assert property (bus_rdata[13] |-> bus_rdata[3:1] == 3'h7)
        else $error("sanity error without class seven");
    // ----------------------------------------
    // Pulses tied to their cause
    // ----------------------------------------
    AST_START_CAUSE: assert property (cmd_start |-> $past(bus_write) && $past(bus_addr) == 4'h0)
        else $error("command start without low pointer write");
    AST_INIT_PULSE: assert property (s_init_wr |=> init_pulse)
        else $error("initialize write gave no pulse");
    AST_INIT_CAUSE: assert property (init_pulse |-> $past(bus_write) && $past(bus_wdata[15]))
        else $error("initialize pulse without request");
    AST_MSG_FOURTH_WORD: assert property (msg_write |-> msg_word_index == 2'h3)
        else $error("message word index not fourth word");
    AST_MSG_CAUSE: assert property (msg_write |-> $past(cmd_done) || $past(attention_event))
        else $error("message store without completion or attention");
    // Main flow seen at least once
    COV_START: cover property (s_low_wr ##1 cmd_start);
endmodule : tape_status_sva

bind tape_ctrl_status_register tape_status_sva #(.DATA_W(DATA_W)) i_tape_status_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .cmd_done(cmd_done), .attention_event(attention_event),
    .bus_rdata(bus_rdata), .cmd_start(cmd_start), .init_pulse(init_pulse),
    .msg_write(msg_write), .msg_word_index(msg_word_index)
);
`default_nettype wire

// ===== verification/tape_msg_buffer_model.sv
`default_nettype none
// Host memory holding the message buffer words
module tape_msg_buffer_model (
    input wire logic clk_sys,
    input wire logic msg_write,
    input wire logic [1:0] msg_word_index,
    input wire logic [15:0] extended_tape_status_word0,
    output logic [15:0] stored_word,
    output int store_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] msg_mem [0:3]; // Four-word buffer image
    initial store_count = 0;
    always @(posedge clk_sys) begin
        if (msg_write) begin
            msg_mem[msg_word_index] <= extended_tape_status_word0;
            store_count <= store_count + 1;
        end
    end
    // Only the extended word slot is of interest here
    assign stored_word = msg_mem[3];
endmodule : tape_msg_buffer_model
`default_nettype wire

// ===== verification/tape_ctrl_status_register_tb_top.sv
`default_nettype none
module tape_ctrl_status_register_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic [3:0] bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_write = 1'h0, bus_read = 1'h0, diag_done = 1'h0, diag_pass = 1'h0;
    logic sanity_fault = 1'h0, dma_bus_error = 1'h0, cmd_done = 1'h0, attention_event = 1'h0;
    logic cmd_is_setup = 1'h0, cmd_buf_addr_ok = 1'h0, cmd_exc = 1'h0;
    logic [2:0] cmd_term_class = 3'h0;
    logic [13:0] xin = 14'h0020; // Live extended status levels, online set
    logic cmd_start, init_pulse, msg_write;
    logic [23:0] cmd_pointer;
    logic [1:0] msg_word_index;
    logic [15:0] bus_rdata, ext_word, stored_word;
    int store_count;
    int mismatches = 0;
    int check_count = 0;
    // Bench model of the status flags
    int spec, sanity, refused, bus_err, need_buf, ready, offline, term, nonexec;
    logic [7:0] ptr_hi;
    always #20 clk_sys = ~clk_sys;
    tape_ctrl_status_register #(.DATA_W(16)) i_tape_ctrl_status_register (
        .clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .diag_done(diag_done),
        .diag_pass(diag_pass), .sanity_fault(sanity_fault), .dma_bus_error(dma_bus_error),
        .cmd_done(cmd_done), .cmd_is_setup(cmd_is_setup), .cmd_buf_addr_ok(cmd_buf_addr_ok),
        .cmd_term_class(cmd_term_class), .cmd_exception(cmd_exc), .attention_event(attention_event),
        .tape_mark_seen(xin[13]), .record_short(xin[12]), .logical_end(xin[11]), .record_long(xin[10]),
        .write_lock_error(xin[9]), .illegal_command(xin[8]), .illegal_address(xin[7]),
        .tape_moving(xin[6]), .transport_online(xin[5]), .interrupt_enable(xin[4]),
        .volume_check(xin[3]), .write_locked(xin[2]), .beginning_of_tape(xin[1]),
        .end_of_tape_marker(xin[0]), .cmd_start(cmd_start), .cmd_pointer(cmd_pointer),
        .init_pulse(init_pulse), .msg_write(msg_write), .msg_word_index(msg_word_index),
        .extended_tape_status_word0(ext_word));
    tape_msg_buffer_model i_tape_msg_buffer_model (.clk_sys(clk_sys), .msg_write(msg_write),
        .msg_word_index(msg_word_index), .extended_tape_status_word0(ext_word),
        .stored_word(stored_word), .store_count(store_count));
    // ----------------------------------------
    // Model functions and bus tasks
    // ----------------------------------------
    function automatic logic [23:0] status_exp();
        status_exp = 24'(spec << 15 | sanity << 13 | refused << 12 | bus_err << 11 | need_buf << 10
            | ready << 7 | offline << 6 | term << 1);
    endfunction : status_exp
    // Extended word layout, nonexecutable made inside the block
    function automatic logic [23:0] ext_exp(input logic [13:0] x, input int n);
        ext_exp = {8'h00, x[13:9], n[0], x[8:3], 1'h0, x[2:0]};
    endfunction : ext_exp
    task automatic chk(input logic [23:0] seen, input logic [23:0] expected);
        check_count++;
        if (seen !== expected) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask : chk
    task automatic tick();
        @(negedge clk_sys);
    endtask : tick
    // One-cycle write strobe, sampled at the next rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_write = 1'h1;
        tick();
        bus_write = 1'h0;
    endtask : wr
    // Status read, data stands one cycle after the strobe
    task automatic rd_chk();
        bus_addr = 4'h2;
        bus_read = 1'h1;
        tick();
        bus_read = 1'h0;
        chk(24'(bus_rdata), status_exp());
    endtask : rd_chk
    task automatic pulse_diag(input logic pass);
        diag_pass = pass;
        diag_done = 1'h1;
        tick();
        diag_done = 1'h0;
    endtask : pulse_diag
    task automatic do_init(input logic pass);
        wr(4'h2, 16'h8000);
        chk(24'(init_pulse), 24'h00_0001);
        {spec, sanity, refused, bus_err, ready, offline, term, ptr_hi} = '0;
        need_buf = 1;
        rd_chk();
        pulse_diag(pass);
        ready = int'(pass);
    endtask : do_init
    task automatic run_cmd(input logic setup, input logic ok, input logic [2:0] cls, input logic online);
        logic [15:0] ptr;
        int msg;
        ptr = 16'($urandom());
        wr(4'h0, ptr);
        chk(24'(cmd_start), 24'h00_0001);
        chk(cmd_pointer, {ptr_hi, ptr});
        ready = 0;
        rd_chk();
        xin = 14'($urandom());
        xin[5] = online;
        msg = int'(need_buf == 0);
        cmd_is_setup = setup;
        cmd_buf_addr_ok = ok;
        cmd_term_class = cls;
        cmd_done = 1'h1;
        tick();
        cmd_done = 1'h0;
        nonexec = 0;
        if (setup && ok) begin
            need_buf = 0;
            term = cls;
        end else if (need_buf != 0) term = 3;
        else if (!online) begin
            term = 3;
            nonexec = 1;
        end else term = cls;
        spec = (term != 0 || cmd_exc) ? 1 : spec;
        ready = 1;
        offline = int'(!online);
        if (msg != 0) chk(24'(msg_write), 24'h00_0001);
        if (msg != 0) chk(24'(ext_word), ext_exp(xin, nonexec));
        tick();
        if (msg != 0) chk(24'(stored_word), ext_exp(xin, nonexec));
        rd_chk();
    endtask : run_cmd
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // Watchdog, far above the roughly 90 cycles needed
    // ----------------------------------------
    initial begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(6));
        {spec, sanity, refused, bus_err, ready, offline, term, nonexec, ptr_hi} = '0;
        need_buf = 1;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'h1;
        rd_chk();
        // Pointer write before ready is dropped
        wr(4'h0, 16'h1234);
        chk(24'(cmd_start), 24'h00_0000);
        refused = 1;
        spec = 1;
        rd_chk();
        $display("test refused write done");
        do_init(1'h1);
        rd_chk();
        wr(4'h2, 16'h00ab);
        chk(24'(init_pulse), 24'h00_0000);
        ptr_hi = 8'hab;
        rd_chk();
        run_cmd(1'h0, 1'h0, 3'h0, 1'h1);
        run_cmd(1'h1, 1'h1, 3'h0, 1'h1);
        $display("test buffer setup done");
        for (int c = 0; c < 7; c++) run_cmd(1'h0, 1'h0, 3'(c), 1'h1);
        run_cmd(1'h0, 1'h0, 3'h0, 1'h0);
        xin[5] = 1'h1;
        tick();
        rd_chk();
        run_cmd(1'h0, 1'h0, 3'h5, 1'h1);
        $display("test classes done");
        xin = 14'($urandom());
        attention_event = 1'h1;
        tick();
        attention_event = 1'h0;
        term = 1;
        chk(24'(msg_write), 24'h00_0001);
        chk(24'(ext_word & 16'hfbff), ext_exp(xin, 0) & 24'h00_fbff);
        rd_chk();
        dma_bus_error = 1'h1;
        tick();
        dma_bus_error = 1'h0;
        bus_err = 1;
        rd_chk();
        $display("test attention and bus error done");
        sanity_fault = 1'h1;
        tick();
        sanity_fault = 1'h0;
        {sanity, term, ready} = {32'd1, 32'd7, 32'd0};
        chk(24'(msg_write), 24'h00_0000);
        rd_chk();
        wr(4'h0, 16'h5678);
        chk(24'(cmd_start), 24'h00_0000);
        refused = 1;
        rd_chk();
        do_init(1'h0);
        bus_addr = 4'h2;
        bus_read = 1'h1;
        tick();
        bus_read = 1'h0;
        chk(24'(bus_rdata & 16'h00be), 24'h00_000e);
        do_init(1'h1);
        rd_chk();
        cmd_exc = 1'h1;
        run_cmd(1'h1, 1'h1, 3'h0, 1'h1);
        chk(24'(store_count), 24'h00_000a);
        $display("test fatal and initialize done");
        end_of_test();
    end
endmodule : tape_ctrl_status_register_tb_top
`default_nettype wire
